//--- hw/idcode_pkg.sv
// Shared constants for the identification code and check block.
// Assumes both ends are built from the same package revision.
package idcode_pkg;
  // ----------------------------------------------------------------
  // Identification code layout
  // ----------------------------------------------------------------
  localparam int unsigned ID_BITS = 64;
  localparam int unsigned TYPE_LSB = 0;
  localparam int unsigned TYPE_BITS = 8;
  localparam int unsigned SERIAL_LSB = 8;
  localparam int unsigned SERIAL_BITS = 48;
  localparam int unsigned CHECK_LSB = 56;
  localparam int unsigned CHECK_BITS = 8;
  localparam int unsigned COVER_BITS = 56;
  // ----------------------------------------------------------------
  // Check generator: x^8 + x^5 + x^4 + 1, reflected form
  // ----------------------------------------------------------------
  localparam logic [7:0] CHECK_POLY_REFL = 8'h8C;
  localparam logic [7:0] CHECK_INIT = 8'h00;
  // ----------------------------------------------------------------
  // Command layer
  // ----------------------------------------------------------------
  localparam int unsigned CMD_BITS = 8;
  localparam int unsigned CMD_COUNT = 8;
  localparam int unsigned CNT_BITS = 7;

  typedef enum logic [2:0] {
    ROM_READ, ROM_MATCH, ROM_SEARCH, ROM_COND_SEARCH,
    ROM_SKIP, ROM_FAST_SKIP, ROM_FAST_MATCH, ROM_RESUME
  } rom_cmd_t;

  typedef enum logic [1:0] {
    AREA_SRAM, AREA_REG_PAGE, AREA_PASSWORD, AREA_LOG
  } area_t;

  // One step of the shift-register check generator, one bit in.
  function automatic logic [7:0] check_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[0] ^ bit_in;
    check_step = (crc >> 1) ^ (fb ? CHECK_POLY_REFL : 8'h00);
  endfunction : check_step
endpackage : idcode_pkg

//--- hw/idcode_if.sv
// Bit-serial link between the bus master and the code-holding device.
// Assumes one shared clock; one bit moves per cycle with bit_valid high.
`timescale 1ns/10ps
`default_nettype none
interface idcode_if;
  logic bit_valid;   // Master to device: bit strobe for commands
  logic bit_data;    // Master to device: bit, LSB first
  logic frame_start; // Master to device: start of a transaction
  logic read_req;    // Master requests one bit from the device
  logic rd_valid;    // Device to master: answer bit strobe
  logic rd_data;     // Device to master: answer bit
  logic fast_mode;   // Device: high-speed mode level

  modport device (
    input bit_valid, bit_data, frame_start, read_req,
    output rd_valid, rd_data, fast_mode
  );
  modport master (
    output bit_valid, bit_data, frame_start, read_req,
    input rd_valid, rd_data, fast_mode
  );
endinterface : idcode_if
`default_nettype wire

//--- hw/idcode_device.sv
// Device end: identification code, its check, command layer and access gate.
// Assumes the master keeps one transaction framed by frame_start.
`timescale 1ns/10ps
`default_nettype none
module idcode_device
  import idcode_pkg::*;
#(
  parameter logic [7:0] TYPE_CODE = 8'h41,             // Arbitrary value
  parameter logic [47:0] SERIAL = 48'h0000_1234_5678   // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Link
  idcode_if.device link,
  // Mission and access
  input wire logic mission_run,
  input wire logic wr_req,
  input wire logic [1:0] wr_area,
  input wire logic rd_req,
  input wire logic [1:0] rd_area,
  output logic wr_allow,
  output logic rd_allow,
  output logic mem_open,
  output logic code_ok
);
  // ----------------------------------------------------------------
  // Code assembly
  // ----------------------------------------------------------------
  // Check computed at elaboration so the code is fixed by construction
  function automatic logic [7:0] cover_check(input logic [55:0] v);
    logic [7:0] c;
    c = CHECK_INIT;
    for (int i = 0; i < int'(COVER_BITS); i++) begin
      c = check_step(c, v[i]);
    end
    return c;
  endfunction : cover_check

  localparam logic [55:0] COVER = {SERIAL, TYPE_CODE};
  localparam logic [63:0] ID_CODE = {cover_check(COVER), COVER};

  // Field views placed by the shared layout; both ends must agree on it
  localparam logic [7:0] TYPE_FIELD = ID_CODE[TYPE_LSB +: TYPE_BITS];
  localparam logic [47:0] SERIAL_FIELD = ID_CODE[SERIAL_LSB +: SERIAL_BITS];
  localparam logic [7:0] CHECK_FIELD = ID_CODE[CHECK_LSB +: CHECK_BITS];

  // Refuse a layout whose fields do not tile the code or misplace a value
  if (TYPE_BITS + SERIAL_BITS + CHECK_BITS != ID_BITS ||
      TYPE_BITS + SERIAL_BITS != COVER_BITS) begin : g_tiling_bad
    $error("code fields do not tile the identification code");
  end
  if (TYPE_FIELD != TYPE_CODE || SERIAL_FIELD != SERIAL) begin : g_field_bad
    $error("type or serial value misplaced in the code");
  end

  // Three layers: ROM command, code readout, memory functions open
  typedef enum logic [1:0] {ST_ROM, ST_SEND, ST_MEM} dev_state_t;

  dev_state_t state_q, state_d;
  logic [6:0] cnt_q, cnt_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] crc_q, crc_d;
  logic fast_q, fast_d;
  logic open_q, open_d;
  logic rdv_q, rdv_d;
  logic rdd_q, rdd_d;
  logic ok_q, ok_d;

  // ----------------------------------------------------------------
  // Command layer and serial readout
  // ----------------------------------------------------------------
  // Code bits stream out on bus power only; nothing here needs battery state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    crc_d = crc_q;
    fast_d = fast_q;
    open_d = open_q;
    rdv_d = 1'b0;
    rdd_d = rdd_q;
    ok_d = ok_q;
    if (link.frame_start) begin
      state_d = ST_ROM;
      cnt_d = '0;
      open_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_ROM: begin
          if (link.bit_valid) begin
            cmd_d = {link.bit_data, cmd_q[7:1]};
            cnt_d = cnt_q + 7'd1;
            if (cnt_q == 7'(CMD_BITS - 1)) begin
              cnt_d = '0;
              open_d = 1'b1;
              state_d = ST_MEM;
              if (cmd_d[2:0] == 3'(ROM_READ)) begin
                state_d = ST_SEND;
                crc_d = CHECK_INIT;
                open_d = 1'b0;
              end
              // Fast mode is entered only from standard speed; a repeat changes nothing
              if (!fast_q && (cmd_d[2:0] == 3'(ROM_FAST_SKIP) ||
                  cmd_d[2:0] == 3'(ROM_FAST_MATCH))) begin
                fast_d = 1'b1;
              end
            end
          end
        end
        ST_SEND: begin
          if (link.read_req) begin
            rdv_d = 1'b1;
            rdd_d = ID_CODE[cnt_q[5:0]];
            // Own check runs beside the readout, so a damaged store shows as code_ok low
            if (cnt_q < 7'(COVER_BITS)) begin
              crc_d = check_step(crc_q, ID_CODE[cnt_q[5:0]]);
            end
            if (cnt_q == 7'(COVER_BITS)) begin
              ok_d = (crc_q == CHECK_FIELD);
            end
            cnt_d = cnt_q + 7'd1;
            if (cnt_q == 7'(ID_BITS - 1)) begin
              state_d = ST_MEM;
              open_d = 1'b1;
            end
          end
        end
        ST_MEM: begin
          state_d = ST_MEM;
        end
        default: state_d = ST_ROM;
      endcase
    end
  end

  // State registers; fast mode is left only by reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_ROM;
      cnt_q <= '0;
      cmd_q <= 8'h00;
      crc_q <= CHECK_INIT;
      fast_q <= 1'b0;
      open_q <= 1'b0;
      rdv_q <= 1'b0;
      rdd_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      crc_q <= crc_d;
      fast_q <= fast_d;
      open_q <= open_d;
      rdv_q <= rdv_d;
      rdd_q <= rdd_d;
      ok_q <= ok_d;
    end
  end

  assign link.rd_valid = rdv_q;
  assign link.rd_data = rdd_q;
  assign link.fast_mode = fast_q;
  assign mem_open = open_q;
  assign code_ok = ok_q;

  // ----------------------------------------------------------------
  // Access gate over the linear space
  // ----------------------------------------------------------------
  // Areas share one linear space; code and staging buffer live outside it
  always_comb begin
    wr_allow = 1'b0;
    rd_allow = 1'b0;
    if (open_q) begin
      // Every area code is decoded, so no access slips through a missing item
      unique case (area_t'(wr_area))
        AREA_SRAM: wr_allow = wr_req;
        AREA_REG_PAGE: wr_allow = wr_req && !mission_run;
        AREA_PASSWORD: wr_allow = wr_req;
        AREA_LOG: wr_allow = 1'b0;
      endcase
      unique case (area_t'(rd_area))
        AREA_PASSWORD: rd_allow = 1'b0;
        AREA_SRAM, AREA_REG_PAGE, AREA_LOG: rd_allow = rd_req;
      endcase
    end
  end
endmodule : idcode_device
`default_nettype wire

//--- hw/idcode_master.sv
// Master end: issues a ROM command, reads the code, verifies the check.
// Assumes the device answers each read request one cycle later.
`timescale 1ns/10ps
`default_nettype none
module idcode_master
  import idcode_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Link
  idcode_if.master link,
  // User side
  input wire logic start,
  input wire logic [2:0] rom_cmd,
  output logic busy,
  output logic done,
  output logic code_valid,
  output logic [63:0] code
);
  typedef enum logic [2:0] {M_IDLE, M_FRAME, M_CMD, M_REQ, M_WAIT, M_CHECK} m_state_t;

  m_state_t st_q, st_d;
  logic [6:0] cnt_q, cnt_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] crc_q, crc_d;
  logic [63:0] code_q, code_d;
  logic done_q, done_d;
  logic valid_q, valid_d;

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  // A bad check restarts the whole read rather than reporting garbage
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    crc_d = crc_q;
    code_d = code_q;
    done_d = 1'b0;
    valid_d = valid_q;
    link.frame_start = 1'b0;
    link.bit_valid = 1'b0;
    link.bit_data = 1'b0;
    link.read_req = 1'b0;
    unique case (st_q)
      M_IDLE: begin
        if (start) begin
          st_d = M_FRAME;
          cmd_d = {5'h00, rom_cmd};
        end
      end
      M_FRAME: begin
        link.frame_start = 1'b1;
        cnt_d = '0;
        crc_d = CHECK_INIT;
        st_d = M_CMD;
      end
      M_CMD: begin
        link.bit_valid = 1'b1;
        link.bit_data = cmd_q[cnt_q[2:0]];
        cnt_d = cnt_q + 7'd1;
        if (cnt_q == 7'(CMD_BITS - 1)) begin
          cnt_d = '0;
          st_d = (cmd_q[2:0] == 3'(ROM_READ)) ? M_REQ : M_IDLE;
          done_d = (cmd_q[2:0] != 3'(ROM_READ));
        end
      end
      M_REQ: begin
        link.read_req = 1'b1;
        st_d = M_WAIT;
      end
      M_WAIT: begin
        if (link.rd_valid) begin
          code_d = {link.rd_data, code_q[63:1]};
          crc_d = check_step(crc_q, link.rd_data);
          cnt_d = cnt_q + 7'd1;
          st_d = (cnt_q == 7'(ID_BITS - 1)) ? M_CHECK : M_REQ;
        end
      end
      M_CHECK: begin
        if (crc_q == 8'h00) begin
          valid_d = 1'b1;
          done_d = 1'b1;
          st_d = M_IDLE;
        end else begin
          valid_d = 1'b0;
          st_d = M_FRAME;
        end
      end
      default: st_d = M_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= M_IDLE;
      cnt_q <= '0;
      cmd_q <= 8'h00;
      crc_q <= CHECK_INIT;
      code_q <= 64'h0;
      done_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      crc_q <= crc_d;
      code_q <= code_d;
      done_q <= done_d;
      valid_q <= valid_d;
    end
  end

  assign busy = (st_q != M_IDLE);
  assign done = done_q;
  assign code_valid = valid_q;
  assign code = code_q;
endmodule : idcode_master
`default_nettype wire

//--- tb/idcode_checker.sv
// Assertions on the serial link that joins the master and device ends.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module idcode_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Link
  input wire logic bit_valid,
  input wire logic bit_data,
  input wire logic frame_start,
  input wire logic read_req,
  input wire logic rd_valid,
  input wire logic rd_data,
  input wire logic fast_mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  // A command byte moves without gaps, so the device never waits
  sequence cmd_byte;
    bit_valid [*8];
  endsequence
  sequence answer;
    ##1 rd_valid;
  endsequence
  cmd_frame_a: assert property (frame_start |=> cmd_byte)
    else $error("command byte not contiguous after frame start");
  frame_quiet_a: assert property (frame_start |-> !bit_valid && !read_req)
    else $error("frame start overlaps traffic");
  answer_lat_a: assert property (read_req |-> answer)
    else $error("no answer one cycle after request");
  no_spurious_a: assert property (rd_valid |-> $past(read_req))
    else $error("answer without request");
  req_space_a: assert property (read_req |=> !read_req && !bit_valid)
    else $error("request spacing broken");
  data_hold_a: assert property (!rd_valid |-> $stable(rd_data))
    else $error("answer bit moved between answers");
  fast_keep_a: assert property (fast_mode |=> fast_mode)
    else $error("fast mode dropped without reset");
  // Fast mode may only follow the end of a command byte
  fast_cause_a: assert property ($rose(fast_mode) |-> $past(bit_valid) || $past(bit_valid, 2))
    else $error("fast mode set without command");
endmodule : idcode_checker
`default_nettype wire

//--- tb/rom_id_crc8_access_layer_tb.sv
// Testbench joining master and device ends through the link interface.
// Assumes the master finishes each command within 400 cycles.
`timescale 1ns/10ps
`default_nettype none
module rom_id_crc8_access_layer_tb;
  import idcode_pkg::*;
  localparam logic [7:0] TYPE_V = 8'h5A; // Arbitrary value
  localparam logic [47:0] SER_V = 48'hA1B2_C3D4_E5F6; // Arbitrary value
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic mission_run = 1'b0;
  logic wr_req = 1'b0;
  logic rd_req = 1'b0;
  logic start = 1'b0;
  logic [1:0] wr_area = 2'h0;
  logic [1:0] rd_area = 2'h0;
  logic [2:0] rom_cmd = 3'h0;
  logic wr_allow, rd_allow, mem_open, code_ok, busy, done, code_valid;
  logic [63:0] code, cap_q, exp_code;
  logic [7:0] cmd_q;
  int n_mismatch = 0;
  int num_checks = 0;
  // ----------------------------------------------------------------
  // Both ends and the checker
  // ----------------------------------------------------------------
  idcode_if i_idcode_if ();
  idcode_device #(.TYPE_CODE(TYPE_V), .SERIAL(SER_V)) i_idcode_device (.clk_sys(clk_sys),
    .resetn(resetn), .link(i_idcode_if.device), .mission_run(mission_run), .wr_req(wr_req),
    .wr_area(wr_area), .rd_req(rd_req), .rd_area(rd_area), .wr_allow(wr_allow),
    .rd_allow(rd_allow), .mem_open(mem_open), .code_ok(code_ok));
  idcode_master i_idcode_master (.clk_sys(clk_sys), .resetn(resetn),
    .link(i_idcode_if.master), .start(start), .rom_cmd(rom_cmd), .busy(busy), .done(done),
    .code_valid(code_valid), .code(code));
  idcode_checker i_idcode_checker (.clk_sys(clk_sys), .resetn(resetn),
    .bit_valid(i_idcode_if.bit_valid), .bit_data(i_idcode_if.bit_data),
    .frame_start(i_idcode_if.frame_start), .read_req(i_idcode_if.read_req),
    .rd_valid(i_idcode_if.rd_valid), .rd_data(i_idcode_if.rd_data),
    .fast_mode(i_idcode_if.fast_mode));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Wire monitor: first bit on the wire lands in bit 0
  always @(posedge clk_sys) begin
    if (i_idcode_if.rd_valid) cap_q <= {i_idcode_if.rd_data, cap_q[63:1]};
    if (i_idcode_if.bit_valid) cmd_q <= {i_idcode_if.bit_data, cmd_q[7:1]};
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Own reference shift register, kept apart from the design's function
  function automatic logic [7:0] crc_ref(input logic [63:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction : crc_ref
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // Bounded wait on done; a hang ends the run
  task automatic run_cmd(input logic [2:0] c);
    int i;
    @(negedge clk_sys);
    rom_cmd = c;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    chk(busy, 1'b1);
    for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk_sys);
    if (i == 400) begin
      n_mismatch++;
      results();
    end
    chk(busy, 1'b0);
    chk(cmd_q, {5'h00, c});
  endtask : run_cmd
  task automatic acc_chk(input logic m, input logic [1:0] a, input logic ew, input logic er);
    @(negedge clk_sys);
    mission_run = m;
    wr_area = a;
    rd_area = a;
    #1;
    chk(wr_allow, ew);
    chk(rd_allow, er);
  endtask : acc_chk
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    exp_code = {crc_ref({8'h00, SER_V, TYPE_V}, 56), SER_V, TYPE_V};
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    wr_req = 1'b1;
    rd_req = 1'b1;
    acc_chk(1'b0, 2'h0, 1'b0, 1'b0);
    run_cmd(3'h0);
    chk(code, exp_code);
    chk(cap_q, exp_code);
    chk(crc_ref(cap_q, 64), 8'h00);
    chk({code_ok, code_valid, mem_open}, 3'h7);
    // Access table: sram, register page, password, log; mission off then on
    for (int m = 0; m < 2; m++) begin
      for (int a = 0; a < 4; a++) begin
        acc_chk(m[0], a[1:0], a == 0 || a == 2 || (a == 1 && m == 0), a != 2);
      end
    end
    mission_run = 1'b0;
    // Command codes 1 to 7; fast mode must stick once entered
    for (int c = 1; c < 8; c++) begin
      run_cmd(c[2:0]);
      chk(i_idcode_if.fast_mode, c >= 5);
    end
    // Reset in mid-run clears fast mode and closes memory
    @(negedge clk_sys);
    resetn = 1'b0;
    @(negedge clk_sys);
    chk({i_idcode_if.fast_mode, mem_open}, 2'h0);
    resetn = 1'b1;
    run_cmd(3'h6);
    chk(i_idcode_if.fast_mode, 1'b1);
    run_cmd(3'h0);
    chk(code, exp_code);
    results();
  end
endmodule : rom_id_crc8_access_layer_tb
`default_nettype wire
